//--- rtl/tmrps_defs.vh
// Register offsets, field positions and reset values for the timer unit.
// Assumes inclusion by the timer design file, the checker and the testbench.
`ifndef TMRPS_DEFS_VH
`define TMRPS_DEFS_VH

// Count word index and byte addresses on the AXI4-Lite bus
`define TMRPS_COUNT_IDX 4'h1
`define TMRPS_COUNT_ADDR 6'h04
`define TMRPS_OPTION_ADDR 6'h08
`define TMRPS_STATUS_ADDR 6'h0c

// Configuration fields
`define TMRPS_CSS_BIT 5
`define TMRPS_SES_BIT 4
`define TMRPS_PSA_BIT 3
`define TMRPS_RATE_MSB 2
`define TMRPS_RATE_LSB 0
`define TMRPS_OPTION_RST 6'h3f

// Cycles of increment suppression after a count write
`define TMRPS_WR_HOLD 2'h2

`define TMRPS_RESP_OKAY 2'b00
`define TMRPS_RESP_SLVERR 2'b10

`endif

//--- rtl/tmrps_prescaler.v
// Shared prescaler: free counter, one-cycle tick at selected ratio.
// Assumes count_pulse is in the aclk domain; each cycle it is high counts once (timer mode holds it high).
`timescale 1ns/1ns
module tmrps_prescaler #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire count_pulse,
  input wire clear,
  input wire [2:0] rate,
  output reg tick_q
);

  reg [WIDTH-1:0] div_q;
  wire [WIDTH-1:0] div_d;
  // Mask selects 2^(rate+1)
  wire [WIDTH-1:0] mask;

  assign div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};
  assign mask = (({{(WIDTH-1){1'b0}}, 1'b1} << rate) << 1) - 
                {{(WIDTH-1){1'b0}}, 1'b1};

  // Count is internal only, never read or loaded by software
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      div_q <= {WIDTH{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (count_pulse) begin
        div_q <= div_d;
        if ((div_d & mask) == {WIDTH{1'b0}}) begin
          tick_q <= 1'b1;
        end
      end
    end
  end

endmodule // tmrps_prescaler

//--- rtl/tmrps_timer.v
// 8-bit timer/counter with shared prescaler, AXI4-Lite register slave.
// Assumes external count pin synchronous to aclk domain logic needs.
// Notes on behaviour
// - Eight-bit count register, software read/write
// - Source select clear picks instruction cycle
// - Timer mode without prescaler counts every cycle
// - Count write blocks increment two cycles
// - Source select set counts pin edges
// - Edge select: clear rising, set falling
// - Prescaler serves timer or watchdog, not both
// - Assign bit clear timer, set watchdog
// - Prescaler count hidden and unloadable
// - Timer ratios 1:2 through 1:256
// - Count at 04h, kept over resets
// - Reset sets all six configuration bits
`timescale 1ns/1ns
`include "tmrps_defs.vh"
module tmrps_timer #(
  parameter PS_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire external_count_pin,
  input wire wdt_clock_pulse,
  output reg wdt_tick_q,
  output reg [7:0] timer_count_q,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  function mapped;
    input [5:0] a;
    begin
      mapped = (a == `TMRPS_COUNT_ADDR) || (a == `TMRPS_OPTION_ADDR) ||
               (a == `TMRPS_STATUS_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect

  reg pin_meta_q;
  reg pin_sync_q;
  reg pin_prev_q;
  always @(posedge aclk) begin
    pin_meta_q <= external_count_pin;
    pin_sync_q <= pin_meta_q;
    pin_prev_q <= pin_sync_q;
  end

  reg [5:0] option_q;
  wire count_source_select = option_q[`TMRPS_CSS_BIT];
  wire source_edge_select = option_q[`TMRPS_SES_BIT];
  wire prescaler_assign = option_q[`TMRPS_PSA_BIT];
  wire [2:0] prescale_rate = option_q[`TMRPS_RATE_MSB:`TMRPS_RATE_LSB];

  wire rise = pin_sync_q & ~pin_prev_q;
  wire fall = ~pin_sync_q & pin_prev_q;
  // Polarity chosen by edge bit, only sync stage observed
  wire pin_event = source_edge_select ? fall : rise;
  // Timer mode counts each cycle, counter mode counts pin edges
  wire src_pulse = count_source_select ? pin_event : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler routing

  // One prescaler, steered by assign bit
  wire ps_in = prescaler_assign ? wdt_clock_pulse : src_pulse;
  wire ps_tick;
  reg psa_prev_q;
  // Reassignment clears prescaler so stale count never leaks across
  wire ps_clear = psa_prev_q != prescaler_assign;

  tmrps_prescaler #(
    .WIDTH(PS_WIDTH)
  ) u_ps (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_pulse(ps_in),
    .clear(ps_clear),
    .rate(prescale_rate),
    .tick_q(ps_tick)
  );

  wire inc_src = prescaler_assign ? src_pulse : ps_tick;
  wire wdt_src = prescaler_assign ? ps_tick : wdt_clock_pulse;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  reg aw_held_q;
  reg w_held_q;
  reg [5:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_q | aw_take;
  wire w_have = w_held_q | w_take;
  wire [5:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire count_wr = wr_fire && wa == `TMRPS_COUNT_ADDR && ws[0];
  wire option_wr = wr_fire && wa == `TMRPS_OPTION_ADDR && ws[0];

  reg [1:0] hold_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMRPS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wa) ? `TMRPS_RESP_OKAY : `TMRPS_RESP_SLVERR;
      end else begin
        aw_held_q <= aw_have;
        w_held_q <= w_have;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count and configuration registers

  // Count has no reset: undefined at power-up, kept over other resets
  always @(posedge aclk) begin
    if (count_wr) begin
      timer_count_q <= wd[7:0];
    end else if (inc_src && hold_q == 2'h0) begin
      timer_count_q <= timer_count_q + 8'h01;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 2'h0;
      option_q <= `TMRPS_OPTION_RST;
      psa_prev_q <= 1'b1;
      wdt_tick_q <= 1'b0;
    end else begin
      psa_prev_q <= prescaler_assign;
      wdt_tick_q <= wdt_src;
      if (count_wr) begin
        hold_q <= `TMRPS_WR_HOLD;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
      if (option_wr) begin
        option_q <= wd[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TMRPS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `TMRPS_RESP_OKAY :
                       `TMRPS_RESP_SLVERR;
        case (s_axi_araddr)
          `TMRPS_COUNT_ADDR: s_axi_rdata <= {24'h000000, timer_count_q};
          `TMRPS_STATUS_ADDR: s_axi_rdata <= {29'h00000000, hold_q,
                                              pin_sync_q};
          // Configuration is write-only; prescaler count never exposed
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // tmrps_timer

//--- tb/tmrps_pin_src.sv
// Partner model: external source toggling the count pin.
// Assumes start is one cycle long; the pin stands still when idle.
`timescale 1ns/1ns
module tmrps_pin_src (
  input wire aclk,
  input wire start,
  input wire [3:0] n_edges,
  input wire [3:0] half,
  output logic pin
);
  logic [3:0] left = 4'h0;
  logic [3:0] tmr = 4'h0;
  initial pin = 1'b0;
  always @(posedge aclk) begin
    if (start) begin
      left <= n_edges;
      tmr <= half;
    end else if (left != 4'h0) begin
      tmr <= (tmr == 4'h1) ? half : tmr - 4'h1;
      if (tmr == 4'h1) begin
        pin <= !pin;
        left <= left - 4'h1;
      end
    end
  end
endmodule // tmrps_pin_src

//--- tb/tmrps_timer_checker.sv
// Port checker for the timer unit.
// Assumes a bus answer one cycle after a request is taken.
`timescale 1ns/1ns
`include "tmrps_defs.vh"
module tmrps_chk (
  input logic aclk,
  input logic aresetn,
  input logic wdt_clock_pulse,
  input logic wdt_tick_q,
  input logic [7:0] timer_count_q,
  input logic [5:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid
);
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire cnt_wr = wr_go && s_axi_awaddr == `TMRPS_COUNT_ADDR;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cnt_land;
    cnt_wr ##1 timer_count_q == $past(s_axi_wdata[7:0]);
  endsequence
  AST_WR_RESP: assert property (wr_go |=> s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while busy");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_CNT_WRITE: assert property (cnt_wr |-> s_cnt_land)
    else $error("count write lost");
  AST_WR_HOLD: assert property (s_cnt_land |=> $stable(timer_count_q)[*2])
    else $error("count moved after write");
  AST_CNT_STEP: assert property (!$past(cnt_wr) &&
    $changed(timer_count_q) |-> timer_count_q == $past(timer_count_q) + 8'h01)
    else $error("count jumped");
  AST_WDT_TICK: assert property (wdt_tick_q |-> $past(wdt_clock_pulse)
    || $past(wdt_clock_pulse, 2)) else $error("stray watchdog tick");
endmodule // tmrps_chk
bind tmrps_timer tmrps_chk i_chk (.*);

//--- tb/tb_top.sv
// Testbench for the timer unit: bus tasks and a scenario sequence.
// Assumes the pin model and the checker are compiled first.
`timescale 1ns/1ns
`include "tmrps_defs.vh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic wp = 1'b0, go = 1'b0, awv = 1'b0, wv = 1'b0, bq = 1'b0;
  logic arv = 1'b0, rq = 1'b0, pin, awr, wrd, bv, arr, rv, tick;
  logic [1:0] bresp, rresp;
  logic [3:0] ne = 4'h0, hf = 4'h0;
  logic [5:0] awa = 6'h00, ara = 6'h00;
  logic [7:0] cnt, c;
  logic [31:0] wd = 32'h0, rdat;
  int err_count = 0, checks = 0, cyc = 0, ticks = 0;
  initial forever #25 aclk = !aclk;
  tmrps_pin_src i_src (.aclk(aclk), .start(go), .n_edges(ne), .half(hf),
    .pin(pin));
  tmrps_timer i_dut (.aclk(aclk), .aresetn(aresetn), .external_count_pin(pin),
    .wdt_clock_pulse(wp), .wdt_tick_q(tick), .timer_count_q(cnt),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bq <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    bq <= 1'b0;
    chk("bresp", bresp, `TMRPS_RESP_OKAY);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
    input logic [1:0] er);
    ara <= a; arv <= 1'b1; rq <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rq <= 1'b0;
    chk("rdata", rdat, e);
    chk("rresp", rresp, er);
    @(posedge aclk);
  endtask
  // Spaced pulses so a prescaled tick can settle between them
  task automatic wdt4(input int exp_ticks);
    ticks = 0;
    repeat (4) begin
      wp <= 1'b1; @(posedge aclk); wp <= 1'b0; repeat (3) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    chk("ticks", ticks, exp_ticks);
  endtask
  task automatic src(input logic [3:0] n, h);
    ne <= n; hf <= h; go <= 1'b1; @(posedge aclk); go <= 1'b0;
    repeat (n * h + 8) @(posedge aclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (tick === 1'b1) ticks++;
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`TMRPS_COUNT_ADDR, 32'h10);
    src(4'h2, 4'h2);
    chk("count", cnt, 8'h11);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TMRPS_COUNT_ADDR, 32'h11, `TMRPS_RESP_OKAY);
    rd(6'h3c, 32'h0, `TMRPS_RESP_SLVERR);
    wr(`TMRPS_OPTION_ADDR, 32'h28);
    src(4'h3, 4'h2);
    chk("count", cnt, 8'h13);
    wr(`TMRPS_OPTION_ADDR, 32'h38);
    src(4'h1, 4'h9);
    chk("count", cnt, 8'h14);
    src(4'h1, 4'h9);
    chk("count", cnt, 8'h14);
    rd(`TMRPS_STATUS_ADDR, 32'h1, `TMRPS_RESP_OKAY);
    rd(`TMRPS_OPTION_ADDR, 32'h0, `TMRPS_RESP_OKAY);
    wr(`TMRPS_OPTION_ADDR, 32'h08);
    wr(`TMRPS_COUNT_ADDR, 32'hfa);
    chk("count", cnt, 8'hfa);
    @(posedge aclk);
    chk("count", cnt, 8'hfa);
    repeat (10) @(posedge aclk);
    chk("count", cnt, 8'h04);
    wdt4(2);
    for (int n = 0; n < 8; n++) begin
      wr(`TMRPS_OPTION_ADDR, n);
      // Skip one more cycle; any reassignment clear has already happened inside wr
      @(posedge aclk);
      c = cnt;
      repeat (4 << (n + 1)) @(posedge aclk);
      chk("count", cnt, c + 8'h04);
    end
    wdt4(4);
    wrap_up;
  end
endmodule // tb_top
